// *** common/host_port_defs.svh ***
/*
 * constants of the synchronous host bus cycle port: address decode fields, byte lane codes,
 * pointer register field positions, reset values and cycle spacing counts.
 * assumes the includer runs on one 25 MHz clock with a synchronous active-high reset.
 */
//
// Function
// - latch address, qualifier, lanes at strobe rise
// - assert claim output after decoding latched address
// - write done pulse lasts exactly one clock
// - write data captured in the clock that drives done low
// - read takes one clock more than write
// - read inserts one delay clock after cycle strobe ends
// - read data stable when done asserts
// - read: hold done and data until ready return
// - local bus mode: single transfers, no bursts
// - direct select bypasses decode, 32-bit data register
// - byte lanes ignored on direct accesses
// - direct select works in both bus modes
// - data register bursts only in synchronous mode
// - ready return inserts burst wait states
// - pointer read bit sets fifo direction
// - pointer receive bit selects rx area
// - pointer auto advance steps fifo address
// - claim only on valid decode with qualifier low
// - burst spacing three clocks read, two write
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ************************************************************
// address decode
// ************************************************************
`define ADDR_W          15
`define DEC_HI          15
`define DEC_LO          4
`define DEC_W           12
`define REG_SEL_HI      3
`define REG_SEL_LO      1
`define BASE_DEFAULT    12'h030
`define DATA_REG_SEL    3'h4
`define PTR_REG_SEL     3'h3

// ************************************************************
// byte lanes and data
// ************************************************************
`define LANES_W         4
`define LANES_ALL       4'h0
`define DATA_W          32

// ************************************************************
// pointer register fields
// ************************************************************
`define PTR_W           16
`define PTR_RX_BIT      15
`define PTR_ADV_BIT     14
`define PTR_READ_BIT    13
`define PTR_ADDR_HI     10
`define PTR_ADDR_LO     0
`define PTR_ADDR_W      11
`define PTR_RESET       16'h0000
`define PTR_STEP        11'h004
`define PTR_ALIGN_MASK  11'h7fc

// ************************************************************
// burst spacing in clocks
// ************************************************************
`define GAP_W           2
`define GAP_READ        2'h3
`define GAP_WRITE       2'h2
`define GAP_ONE         2'h1
`define GAP_ZERO        2'h0

`endif

// *** common/host_port_pkg.sv ***
/*
 * types of the synchronous host bus cycle port.
 * assumes host_port_defs.svh is on the include path.
 */
package host_port_pkg;
`include "host_port_defs.svh"

   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'h0,
      ST_ADDR    = 3'h1,
      ST_DELAY   = 3'h3,
      ST_READY   = 3'h2,
      ST_HOLD    = 3'h6,
      ST_BURST   = 3'h7
   } cycleState_t;

   typedef logic [`DATA_W-1:0]  word_t;
   typedef logic [`PTR_W-1:0]   ptr_t;
   typedef logic [`ADDR_W-1:0]  addr_t;

endpackage : host_port_pkg

// *** verilog/gap_counter.sv ***
/*
 * down counter that enforces the least spacing between direct data register burst beats.
 * assumes the caller loads it in the cycle a transfer is taken.
 */
`timescale 1ns/10ps
`include "host_port_defs.svh"

module gap_counter
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // control
   input  wire logic                 load,
   input  wire logic [`GAP_W-1:0]    loadValue,
   // status
   output logic                      gapOpen
);

   logic [`GAP_W-1:0] count_q;
   logic [`GAP_W-1:0] count_d;

   always_comb
   begin
      count_d = count_q;
      if (load)
         count_d = loadValue - `GAP_ONE;
      else if (count_q != `GAP_ZERO)
         count_d = count_q - `GAP_ONE;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         count_q <= `GAP_ZERO;
      else
         count_q <= count_d;
   end

   assign gapOpen = (count_q == `GAP_ZERO);

endmodule // gap_counter

// *** verilog/sync_host_bus_cycle_port.sv ***
/*
 * synchronous host bus cycle port: single read and write cycles with address latch,
 * cycle claim, done strobe and ready return, plus direct data register access steered
 * by the pointer register. holds the pointer register only; the fifo window lives outside
 * on the fifo ports and register contents beyond it live outside on the intReg ports.
 * assumes all inputs are synchronous to clk and that the master keeps its own rules.
 */
`timescale 1ns/10ps
`include "host_port_defs.svh"

module sync_host_bus_cycle_port
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       srst,
   // mode and decode configuration
   input  wire logic                       local_bus_mode_select_n,
   input  wire logic [`DEC_W-1:0]          baseAddr,
   // address phase
   input  wire host_port_pkg::addr_t       hostAddr,
   input  wire logic                       addr_qualifier_n,
   input  wire logic [`LANES_W-1:0]        byte_lane_enable_n,
   input  wire logic                       addr_strobe_n,
   // cycle control
   input  wire logic                       cycle_strobe_n,
   input  wire logic                       write_not_read,
   input  wire logic                       ready_return_n,
   input  wire logic                       direct_fifo_select_n,
   // data bus
   input  wire host_port_pkg::word_t       dataIn,
   output host_port_pkg::word_t            dataOut,
   output logic                            dataOutEn_n,
   // cycle answers
   output logic                            cycle_claim_n,
   output logic                            xfer_done_n,
   // internal register side
   output logic                            intRegWrite,
   output logic [`REG_SEL_HI:`REG_SEL_LO]  intRegSel,
   output logic [`LANES_W-1:0]             intRegLanes_n,
   output host_port_pkg::word_t            intRegWData,
   input  wire host_port_pkg::word_t       intRegRData,
   // fifo side
   output logic                            fifoStrobe,
   output logic                            fifoWrite,
   output logic                            rx_area_select,
   output logic                            ptr_auto_advance,
   output logic [`PTR_ADDR_W-1:0]          fifoAddr,
   output host_port_pkg::word_t            fifoWData,
   input  wire host_port_pkg::word_t       fifoRData,
   // status
   output host_port_pkg::ptr_t             ptrValue,
   output host_port_pkg::cycleState_t      cycleState
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      cycleState_t                     st;
      addr_t                           addr;
      logic                            qual_n;
      logic [`LANES_W-1:0]             lanes_n;
      logic                            direct;
      logic                            isWrite;
      logic                            adsPrev;
      logic                            claim_n;
      logic                            done_n;
      word_t                           rdata;
      logic                            oe_n;
      ptr_t                            ptr;
      logic                            regWr;
      logic                            fStb;
      logic                            fWr;
      word_t                           wdata;
      logic [`PTR_ADDR_W-1:0]          fAddr;
   } portState_t;

   portState_t s_q;
   portState_t s_d;

   logic       gapOpen;
   logic       gapLoad;
   logic [`GAP_W-1:0] gapValue;
   logic       decodeHit;
   logic       isPtrReg;
   logic       syncMode;

   // ************************************************************
   // spacing of direct burst beats
   // ************************************************************
   gap_counter spacing
   (
      .clk       (clk),
      .srst      (srst),
      .load      (gapLoad),
      .loadValue (gapValue),
      .gapOpen   (gapOpen)
   );

   // decode uses only the latched copy so address may change after the strobe
   assign decodeHit = (s_q.addr[`DEC_HI-1:`DEC_LO] == baseAddr[`DEC_W-2:0])
                      && !s_q.qual_n;
   assign isPtrReg  = (s_q.addr[`REG_SEL_HI:`REG_SEL_LO] == `PTR_REG_SEL);
   assign syncMode  = 1'b1; // the whole port is clocked; async strobes are not modelled

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      s_d         = s_q;
      s_d.adsPrev = addr_strobe_n;
      s_d.regWr   = 1'b0;
      s_d.fStb    = 1'b0;
      gapLoad     = 1'b0;
      gapValue    = `GAP_WRITE;

      // rising edge of the address strobe latches address, qualifier and lanes
      if (!s_q.adsPrev && addr_strobe_n)
      begin
         s_d.addr    = hostAddr;
         s_d.qual_n  = addr_qualifier_n;
         s_d.lanes_n = byte_lane_enable_n;
         s_d.direct  = !direct_fifo_select_n;
      end

      case (s_q.st)
         ST_IDLE:
         begin
            s_d.claim_n = 1'b1;
            s_d.done_n  = 1'b1;
            s_d.oe_n    = 1'b1;
            if (!s_q.adsPrev && addr_strobe_n)
               s_d.st = ST_ADDR;
            else if (!direct_fifo_select_n && !cycle_strobe_n && local_bus_mode_select_n
                     && syncMode && gapOpen && ready_return_n)
            begin
               // direct burst beat, paced by ready return and spacing
               s_d.direct  = 1'b1;
               s_d.isWrite = write_not_read;
               // address goes out a clock early so burst read data is current
               s_d.fAddr   = s_q.ptr[`PTR_ADDR_HI:`PTR_ADDR_LO] & `PTR_ALIGN_MASK;
               s_d.st      = ST_BURST;
            end
         end
         ST_ADDR:
         begin
            if (s_q.direct || decodeHit)
               s_d.claim_n = s_q.direct;
            if (!(s_q.direct || decodeHit))
               s_d.st = ST_IDLE;
            else if (!cycle_strobe_n)
            begin
               s_d.isWrite = write_not_read;
               s_d.st      = ST_READY;
            end
         end
         ST_DELAY:
         begin
            s_d.rdata  = s_q.direct ? fifoRData : intRegRData;
            s_d.oe_n   = 1'b0;
            s_d.done_n = 1'b0;
            s_d.st     = ST_HOLD;
         end
         ST_READY:
         begin
            if (cycle_strobe_n && s_q.isWrite)
            begin
               s_d.done_n = 1'b0;
               s_d.wdata  = dataIn;
               s_d.st     = ST_HOLD;
            end
            else if (cycle_strobe_n)
            begin
               // read needs one extra fetch clock before data is offered
               s_d.fAddr = s_q.ptr[`PTR_ADDR_HI:`PTR_ADDR_LO] & `PTR_ALIGN_MASK;
               s_d.st    = ST_DELAY;
            end
         end
         ST_HOLD:
         begin
            if (s_q.isWrite)
            begin
               // done drops for exactly one clock while data is taken
               s_d.done_n = 1'b1;
               if (s_q.direct || s_q.ptr[`PTR_READ_BIT])
               begin
                  s_d.fStb  = s_q.direct;
                  s_d.fWr   = !s_q.ptr[`PTR_READ_BIT];
                  s_d.fAddr = s_q.ptr[`PTR_ADDR_HI:`PTR_ADDR_LO] & `PTR_ALIGN_MASK;
               end
               if (!s_q.direct && isPtrReg)
                  s_d.ptr = s_q.wdata[`PTR_W-1:0];
               s_d.regWr   = !s_q.direct;
               s_d.claim_n = 1'b1;
               s_d.st      = ST_IDLE;
            end
            else if (!ready_return_n)
            begin
               // data and done stand until ready return is seen
               s_d.done_n  = 1'b1;
               s_d.oe_n    = 1'b1;
               s_d.claim_n = 1'b1;
               s_d.fStb    = s_q.direct;
               s_d.fWr     = 1'b0;
               s_d.st      = ST_IDLE;
            end
         end
         ST_BURST:
         begin
            s_d.fStb  = 1'b1;
            s_d.fWr   = s_q.isWrite && !s_q.ptr[`PTR_READ_BIT];
            // whole words only: the two low pointer bits never reach the fifo
            s_d.fAddr = s_q.ptr[`PTR_ADDR_HI:`PTR_ADDR_LO] & `PTR_ALIGN_MASK;
            s_d.wdata = dataIn;
            if (!s_q.isWrite)
            begin
               s_d.rdata = fifoRData;
               s_d.oe_n  = 1'b0;
            end
            gapLoad  = 1'b1;
            gapValue = s_q.isWrite ? `GAP_WRITE : `GAP_READ;
            s_d.st   = ST_IDLE;
         end
         default:
            s_d.st = ST_IDLE;
      endcase

      // every fifo access steps the pointer when advance is on
      if (s_q.fStb && s_q.ptr[`PTR_ADV_BIT])
         s_d.ptr[`PTR_ADDR_HI:`PTR_ADDR_LO] =
            (s_q.ptr[`PTR_ADDR_HI:`PTR_ADDR_LO] & `PTR_ALIGN_MASK) + `PTR_STEP;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_q         <= '0;
         s_q.st      <= ST_IDLE;
         s_q.adsPrev <= 1'b1;
         s_q.qual_n  <= 1'b1;
         s_q.lanes_n <= `LANES_ALL;
         s_q.claim_n <= 1'b1;
         s_q.done_n  <= 1'b1;
         s_q.oe_n    <= 1'b1;
         s_q.ptr     <= `PTR_RESET;
      end
      else
         s_q <= s_d;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign dataOut          = s_q.rdata;
   assign dataOutEn_n      = s_q.oe_n;
   assign cycle_claim_n    = s_q.claim_n;
   assign xfer_done_n      = s_q.done_n;
   assign intRegWrite      = s_q.regWr;
   assign intRegSel        = s_q.addr[`REG_SEL_HI:`REG_SEL_LO];
   assign intRegLanes_n    = s_q.lanes_n;
   assign intRegWData      = s_q.wdata;
   assign fifoStrobe       = s_q.fStb;
   assign fifoWrite        = s_q.fWr;
   assign rx_area_select   = s_q.ptr[`PTR_RX_BIT];
   assign ptr_auto_advance = s_q.ptr[`PTR_ADV_BIT];
   assign fifoAddr         = s_q.fAddr;
   assign fifoWData        = s_q.wdata;
   assign ptrValue         = s_q.ptr;
   assign cycleState       = s_q.st;

endmodule // sync_host_bus_cycle_port

// *** bench/host_port_sva.sv ***
/* checker of the host bus cycle port, bound to its ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module host_port_sva
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // master side
   input wire addr_t       hostAddr,
   input wire logic [11:0] baseAddr,
   input wire logic        addr_qualifier_n,
   input wire logic        addr_strobe_n,
   input wire logic        direct_fifo_select_n,
   input wire logic        cycle_strobe_n,
   input wire logic        write_not_read,
   input wire logic        ready_return_n,
   // answers
   input wire word_t       dataOut,
   input wire logic        dataOutEn_n,
   input wire logic        cycle_claim_n,
   input wire logic        xfer_done_n,
   input wire logic        fifoStrobe,
   input wire logic        fifoWrite,
   input wire logic        rx_area_select,
   input wire logic        ptr_auto_advance,
   input wire ptr_t        ptrValue,
   input wire cycleState_t cycleState
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic hit;
   assign hit = !addr_qualifier_n && hostAddr[14:4] == baseAddr[10:0];
   claim_hit_a:
   assert property ($rose(addr_strobe_n) && cycleState == ST_IDLE && hit && direct_fifo_select_n
      |-> ##2 !cycle_claim_n) else $error("claim missing after hit");
   miss_silent_a:
   assert property ($rose(addr_strobe_n) && addr_qualifier_n && direct_fifo_select_n
      && cycleState == ST_IDLE |=> cycle_claim_n [*3]) else $error("claim on a miss");
   write_time_a:
   assert property ($rose(cycle_strobe_n) && write_not_read && !cycle_claim_n
      |=> $fell(xfer_done_n) ##1 xfer_done_n) else $error("write done timing");
   read_time_a:
   assert property ($rose(cycle_strobe_n) && !write_not_read && !cycle_claim_n
      |-> xfer_done_n [*2] ##1 !xfer_done_n) else $error("read done timing");
   read_hold_a:
   assert property (!xfer_done_n && !write_not_read && ready_return_n
      |=> !xfer_done_n && $stable(dataOut)) else $error("read answer dropped");
   read_drive_a:
   assert property (!xfer_done_n && !write_not_read |-> !dataOutEn_n)
      else $error("read data not driven");
   read_end_a:
   assert property (!xfer_done_n && !write_not_read && !ready_return_n
      |=> xfer_done_n && dataOutEn_n ##[0:1] cycleState == ST_IDLE) else $error("read end");
   ptr_bits_a:
   assert property ($stable(ptrValue) |-> rx_area_select == ptrValue[15]
      && ptr_auto_advance == ptrValue[14]) else $error("pointer bits not shown");
   fifo_dir_a:
   assert property (fifoStrobe |-> fifoWrite == !ptrValue[13]) else $error("fifo direction");
   ptr_step_a:
   assert property (fifoStrobe && ptr_auto_advance |=> ptrValue[10:0]
      == ((11'($past(ptrValue)) & 11'h7fc) + 11'h004)) else $error("pointer step");
endmodule // host_port_sva
bind sync_host_bus_cycle_port host_port_sva u_sva (.clk, .srst, .hostAddr, .baseAddr,
   .addr_qualifier_n, .addr_strobe_n, .direct_fifo_select_n, .cycle_strobe_n, .write_not_read,
   .ready_return_n, .dataOut, .dataOutEn_n, .cycle_claim_n, .xfer_done_n, .fifoStrobe,
   .fifoWrite, .rx_area_select, .ptr_auto_advance, .ptrValue, .cycleState);

// *** bench/host_master_model.sv ***
/* bus master model: one single cycle per call of xfer.
   assumes one caller at a time; it drives on falling edges. */
`timescale 1ns/10ps
module host_master_model
   import host_port_pkg::*;
(
   // clock
   input  wire logic        clk,
   // master drives
   output addr_t            hostAddr,
   output logic             addr_qualifier_n,
   output logic [3:0]       byte_lane_enable_n,
   output logic             addr_strobe_n,
   output logic             cycle_strobe_n,
   output logic             write_not_read,
   output logic             ready_return_n,
   output logic             direct_fifo_select_n,
   output word_t            dataIn,
   // device answers
   input  wire logic        xfer_done_n,
   input  wire word_t       dataOut
);
   initial
   begin
      {addr_strobe_n, cycle_strobe_n, ready_return_n, direct_fifo_select_n} = 4'hf;
      {addr_qualifier_n, write_not_read, byte_lane_enable_n, hostAddr, dataIn} = '1;
   end
   task automatic xfer(input addr_t a, input logic q, input logic [3:0] ln, input logic dn,
      input logic wr, input word_t wd, input int stall, output word_t rd, output logic ok);
      int k;
      @(negedge clk);
      {hostAddr, addr_qualifier_n, byte_lane_enable_n, direct_fifo_select_n} = {a, q, ln, dn};
      addr_strobe_n = 1'b0;
      @(negedge clk);
      addr_strobe_n = 1'b1;
      @(negedge clk);
      {hostAddr, byte_lane_enable_n} = ~{a, ln}; // stale lines change after latch
      cycle_strobe_n = 1'b0; // one clock behind the address strobe
      write_not_read = wr;
      @(negedge clk);
      cycle_strobe_n = 1'b1;
      dataIn = wd;
      for (k = 0; k < 8 && xfer_done_n !== 1'b0; k++)
         @(negedge clk);
      ok = !xfer_done_n;
      rd = dataOut;
      repeat (stall) @(negedge clk);
      ready_return_n = !(ok && !wr); // slow answers stretch the hold
      @(negedge clk);
      {ready_return_n, addr_qualifier_n, direct_fifo_select_n} = 3'h7;
      dataIn = ~wd;
      @(negedge clk);
      write_not_read = ~wr; // only after done has ended
   endtask
   task automatic beat(input logic wr, input word_t wd, input int hold, output word_t rd);
      @(negedge clk);
      {direct_fifo_select_n, cycle_strobe_n, write_not_read, dataIn} = {2'b00, wr, wd};
      ready_return_n = (hold == 0); // wait states hold the beat off
      if (hold != 0)
      begin
         repeat (hold) @(negedge clk);
         ready_return_n = 1'b1;
      end
      @(negedge clk);
      {direct_fifo_select_n, cycle_strobe_n} = 2'b11;
      @(negedge clk);
      rd = dataOut;
      repeat (2) @(negedge clk); // keeps the beat spacing
   endtask
endmodule // host_master_model

// *** bench/sync_host_bus_cycle_port_tb_top.sv ***
/* bench of the host bus cycle port: register cycles, misses, direct fifo access.
   assumes the master model and the bound checker are compiled with it. */
`timescale 1ns/10ps
module sync_host_bus_cycle_port_tb_top;
   import host_port_pkg::*;
   // ****************
   // signals
   // ****************
   logic clk, srst, ok, local_bus_mode_select_n;
   logic [11:0] baseAddr;
   addr_t hostAddr;
   logic addr_qualifier_n, addr_strobe_n, cycle_strobe_n, write_not_read, ready_return_n;
   logic direct_fifo_select_n, dataOutEn_n, cycle_claim_n, xfer_done_n, intRegWrite;
   logic fifoStrobe, fifoWrite, rx_area_select, ptr_auto_advance;
   logic [3:0] byte_lane_enable_n, intRegLanes_n;
   logic [2:0] intRegSel, sel;
   logic [10:0] fifoAddr, ea;
   word_t dataIn, dataOut, intRegWData, intRegRData, fifoWData, fifoRData, seed, r, d, rd;
   ptr_t ptrValue, p;
   cycleState_t cycleState;
   logic [38:0] wq[$], we;
   logic [43:0] fq[$], fe;
   int errTotal, nChecks, cyc, i, j;
   assign intRegRData = {8'hc3, 21'h0, intRegSel};
   assign fifoRData = {8'h5a, 13'h0, fifoAddr};
   sync_host_bus_cycle_port u_dut (.clk, .srst, .local_bus_mode_select_n, .baseAddr,
      .hostAddr, .addr_qualifier_n, .byte_lane_enable_n, .addr_strobe_n, .cycle_strobe_n,
      .write_not_read, .ready_return_n, .direct_fifo_select_n, .dataIn, .dataOut,
      .dataOutEn_n, .cycle_claim_n, .xfer_done_n, .intRegWrite, .intRegSel, .intRegLanes_n,
      .intRegWData, .intRegRData, .fifoStrobe, .fifoWrite, .rx_area_select,
      .ptr_auto_advance, .fifoAddr, .fifoWData, .fifoRData, .ptrValue, .cycleState);
   host_master_model u_mst (.clk, .hostAddr, .addr_qualifier_n, .byte_lane_enable_n,
      .addr_strobe_n, .cycle_strobe_n, .write_not_read, .ready_return_n,
      .direct_fifo_select_n, .dataIn, .xfer_done_n, .dataOut);
   // ****************
   // helpers
   // ****************
   function automatic word_t rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      nChecks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic finishTest();
      $display("TB: checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic setPtr(input ptr_t v);
      u_mst.xfer({baseAddr[10:0], 3'h3, 1'b0}, 1'b0, 4'h0, 1'b1, 1'b1, {16'h0, v}, 0, rd, ok);
      chk("pointer", v, ptrValue);
      wq.delete();
   endtask
   // sampling of the internal side; also cuts a hang short
   always @(posedge clk)
   begin
      if (intRegWrite === 1'b1)
         wq.push_back({intRegLanes_n, intRegSel, intRegWData});
      if (fifoStrobe === 1'b1)
         fq.push_back({fifoWrite, fifoAddr, fifoWData});
      cyc++;
      if (cyc == 5000)
      begin
         errTotal++;
         finishTest();
      end
   end
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ****************
   // tests
   // ****************
   initial
   begin
      seed = 32'hdc9a383f;
      srst = 1'b1;
      baseAddr = 12'h5a3;
      local_bus_mode_select_n = 1'b0;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk("reset ptr", 16'h0000, ptrValue);
      chk("reset answers", 2'h3, {cycle_claim_n, xfer_done_n});
      for (i = 0; i < 6; i++)
      begin
         sel = (i < 3) ? i[2:0] : i[2:0] + 3'h2;
         d = rnd();
         r = rnd();
         u_mst.xfer({baseAddr[10:0], sel, 1'b0}, 1'b0, r[3:0], 1'b1, 1'b1, d, 0, rd, ok);
         chk("write count", 1, wq.size());
         we = wq.pop_front();
         chk("write item", {r[3:0], sel, d}, we);
         u_mst.xfer({baseAddr[10:0], sel, 1'b0}, 1'b0, r[3:0], 1'b1, 1'b0, d, i % 3, rd, ok);
         chk("read data", {8'hc3, 21'h0, sel}, rd);
      end
      $display("TB: register cycles done");
      for (i = 0; i < 4; i++)
      begin
         u_mst.xfer({baseAddr[10:0] ^ {i[1], 10'h0}, 3'h1, 1'b0}, !i[1], 4'h0, 1'b1, i[0],
            rnd(), 0, rd, ok);
         chk("miss done", 0, ok);
         chk("miss write", 0, wq.size());
      end
      $display("TB: misses done");
      for (i = 0; i < 8; i++)
         for (j = 0; j < 2; j++)
         begin
            if (j == 0 || !i[1])
            begin
               r = rnd();
               p = {i[2:0], 2'b00, (i[1] ? r[10:0] : (r[10:0] & 11'h7fc))};
               local_bus_mode_select_n = i[2];
               setPtr(p);
               ea = r[10:0] & 11'h7fc;
            end
            d = rnd();
            u_mst.xfer(d[14:0], 1'b0, d[3:0], 1'b0, !i[0], d, j, rd, ok);
            chk("fifo count", 1, fq.size());
            fe = fq.pop_front();
            chk("fifo dir", !i[0], fe[43]);
            chk("fifo addr", ea, fe[42:32]);
            chk("rx area", i[2], rx_area_select);
            chk("fifo data", i[0] ? {8'h5a, 13'h0, ea} : d, i[0] ? rd : fe[31:0]);
            if (i[1])
               ea += 11'h004;
         end
      $display("TB: direct fifo done");
      local_bus_mode_select_n = 1'b1;
      for (i = 0; i < 2; i++)
      begin
         r = rnd();
         setPtr({2'b01, i[0], 2'b00, r[10:0]});
         ea = r[10:0] & 11'h7fc;
         for (j = 0; j < 2; j++)
         begin
            d = rnd();
            u_mst.beat(!i[0], d, j, rd);
            chk("burst count", 1, fq.size());
            fe = fq.pop_front();
            chk("burst dir", !i[0], fe[43]);
            chk("burst addr", ea, fe[42:32]);
            chk("burst data", i[0] ? {8'h5a, 13'h0, ea} : d, i[0] ? rd : fe[31:0]);
            ea += 11'h004;
         end
      end
      local_bus_mode_select_n = 1'b0;
      u_mst.beat(1'b1, rnd(), 0, rd);
      chk("burst refused", 0, fq.size());
      $display("TB: bursts done");
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk("rerun ptr", 16'h0000, ptrValue);
      chk("rerun state", ST_IDLE, cycleState);
      $display("TB: mid-run reset done");
      finishTest();
   end
endmodule // sync_host_bus_cycle_port_tb_top
